// file: inc/flash_params.svh
// Constants for the dual-line serial flash front end.
// Assumes a 40 MHz core_clk sampling a slower external serial clock.
`ifndef FLASH_PARAMS_SVH
`define FLASH_PARAMS_SVH

`define OP_READ            8'h03
`define OP_DUAL_READ       8'h3b
`define OP_PAGE_PROG       8'h02
`define OP_DUAL_PROG       8'ha2
`define OP_OTP_READ        8'h4b
`define OP_OTP_PROG        8'h42
`define OP_SUB_ERASE       8'h20
`define OP_SEC_ERASE       8'hd8
`define OP_BULK_ERASE      8'hc7
`define OP_WRITE_EN        8'h06
`define OP_SET_LOCK        8'he5
`define ADDR_BITS          20
`define PAGE_BYTES         9'h100
`define OTP_BYTES          7'h40
`define OTP_LOCK_IDX       6'h3f
`define SECTOR_LSB         16
`define SUBSECTOR_LSB      12
`define BUSY_CYCLES        16'h0040

`endif

// file: inc/flash_pkg.sv
// Types shared by the serial flash front end modules.
// Assumes flash_params.svh supplies the numbers.
package flash_pkg;
    typedef enum logic [2:0] {
        PH_CMD,
        PH_ADDR,
        PH_DUMMY,
        PH_DATA,
        PH_IDLE
    } phase_e;

    typedef enum logic [2:0] {
        JOB_NONE,
        JOB_PROG,
        JOB_SUB,
        JOB_SEC,
        JOB_BULK,
        JOB_OTP
    } job_e;
endpackage

// file: inc/edge_if.sv
// Sampled serial pin events passed from the pin synchroniser to the core.
// Assumes all members are on core_clk.
`timescale 1ns/1ps
interface edge_if;
    logic       sel;
    logic       sel_fall;
    logic       sel_rise;
    logic       held;
    logic       rise;
    logic       fall;
    logic [1:0] din;

    modport src (output sel, output sel_fall, output sel_rise, output held, output rise,
                 output fall, output din);
    modport dst (input sel, input sel_fall, input sel_rise, input held, input rise,
                 input fall, input din);
endinterface

// file: hdl/pin_sync.sv
// Synchronises serial pins into core_clk and finds their edges.
// Assumes pins are asynchronous to core_clk.
`timescale 1ns/1ps
module pin_sync (
    input  wire logic  core_clk,
    input  wire logic  reset,
    input  wire logic  sclk,
    input  wire logic  cs_n,
    input  wire logic  hold_n,
    input  wire logic  io_line_zero_in,
    input  wire logic  io_line_one_in,
    edge_if.src        ev
);
    logic [4:0] meta_ff;
    logic [4:0] sync_ff;
    logic       sclk_old_ff;
    logic       sel_old_ff;
    logic       act;

    // No reset on pin stages: they follow the pins through reset,
    // else a select held low across reset reads as a fresh edge
    always_ff @(posedge core_clk) begin
        meta_ff <= {io_line_one_in, io_line_zero_in, hold_n, cs_n, sclk};
        sync_ff <= meta_ff;
    end

    always_ff @(posedge core_clk) begin
        sclk_old_ff <= sync_ff[0];
        sel_old_ff  <= ~sync_ff[1];
    end

    assign ev.sel      = ~sync_ff[1];
    assign ev.sel_fall = ~reset & ~sync_ff[1] & ~sel_old_ff;
    assign ev.sel_rise = ~reset & sync_ff[1] & sel_old_ff;
    assign act         = ~reset & ~sync_ff[1] & sync_ff[2];
    assign ev.held     = ~reset & ~sync_ff[1] & ~sync_ff[2];
    assign ev.rise     = act & sync_ff[0] & ~sclk_old_ff;
    assign ev.fall     = act & ~sync_ff[0] & sclk_old_ff;
    assign ev.din      = sync_ff[4:3];
endmodule // pin_sync

// file: hdl/flash_store.sv
// Byte storage: main array, one-time area, its lock bit; sector protection bits are inputs.
// Assumes one write or erase request per cycle from the front end.
`timescale 1ns/1ps
`include "flash_params.svh"
module flash_store (
    input  wire logic                   core_clk,
    input  wire logic                   reset,
    input  wire logic [`ADDR_BITS-1:0]  addr,
    input  wire logic                   otp_sel,
    input  wire logic                   wr_en,
    input  wire logic [7:0]             wr_data,
    input  wire logic                   erase_en,
    input  wire flash_pkg::job_e        erase_kind,
    input  wire logic                   otp_lock_set,
    input  wire logic [15:0]            prot_nv,
    input  wire logic [15:0]            prot_vol,
    output logic [7:0]                  rd_data,
    output logic                        otp_locked
);
    logic [7:0]  mem_ff [0:(1<<`ADDR_BITS)-1];
    logic [7:0]  otp_ff [0:63];
    logic        lock_ff;
    logic [3:0]  sec;

    function automatic logic is_prot(input logic [3:0] s, input logic [15:0] a,
                                     input logic [15:0] b);
        is_prot = a[s] | b[s];
    endfunction

    assign sec        = addr[`ADDR_BITS-1:`SECTOR_LSB];
    assign otp_locked = lock_ff;
    assign rd_data    = otp_sel ? otp_ff[addr[5:0]] : mem_ff[addr];

    always_ff @(posedge core_clk) begin
        if (reset)
            lock_ff <= 1'b0;
        else if (otp_lock_set)
            lock_ff <= 1'b1;
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            // Reset gives the erased delivery state of the area
            for (int j = 0; j < 64; j++) begin
                otp_ff[j] <= 8'hff;
            end
        end else if (wr_en && otp_sel && !lock_ff)
            otp_ff[addr[5:0]] <= otp_ff[addr[5:0]] & wr_data;
    end

    // erase decode on sector and subsector bits
    always_ff @(posedge core_clk) begin
        if (wr_en && !otp_sel && !is_prot(sec, prot_nv, prot_vol))
            mem_ff[addr] <= mem_ff[addr] & wr_data;
        else if (erase_en) begin
            for (int i = 0; i < (1<<`ADDR_BITS); i++) begin
                if (erase_kind == flash_pkg::JOB_BULK && prot_nv == 16'h0000
                        && prot_vol == 16'h0000)
                    mem_ff[i] <= 8'hff;
                else if (erase_kind == flash_pkg::JOB_SEC && !is_prot(sec, prot_nv, prot_vol)
                        && i[19:16] == sec)
                    mem_ff[i] <= 8'hff;
                else if (erase_kind == flash_pkg::JOB_SUB && !is_prot(sec, prot_nv, prot_vol)
                        && i[19:12] == addr[19:12])
                    mem_ff[i] <= 8'hff;
            end
        end
    end
endmodule // flash_store

// file: hdl/serial_flash.sv
// Serial slave front end: command decode, shifting, internal busy cycle.
// Assumes master uses clock mode 0,0 or 1,1 and stays below core_clk/4.
`timescale 1ns/1ps
`include "flash_params.svh"
module serial_flash (
    input  wire logic  core_clk,
    input  wire logic  reset,
    input  wire logic  sclk,
    input  wire logic  cs_n,
    input  wire logic  hold_n,
    input  wire logic  io_line_zero_in,
    output logic       io_line_zero_out,
    output logic       io_line_zero_oe,
    input  wire logic  io_line_one_in,
    output logic       io_line_one_out,
    output logic       io_line_one_oe,
    input  wire logic  [15:0] prot_nv,
    output logic       busy,
    output logic       standby
);
    edge_if ev ();

    flash_pkg::phase_e  ph_ff;
    flash_pkg::job_e    job_ff;
    logic [7:0]         cmd_ff;
    logic [7:0]         sh_ff;
    logic [5:0]         cnt_ff;
    logic [`ADDR_BITS-1:0] addr_ff;
    logic               armed_ff;
    logic               wel_ff;
    logic [15:0]        busy_cnt_ff;
    logic [15:0]        prot_vol_ff;
    logic [8:0]         nbytes_ff;
    logic               z_out_ff, z_oe_ff, o_out_ff, o_oe_ff;
    logic               busy_ff, standby_ff;
    logic               wr_pulse_ff, erase_ff, lock_ff;
    logic [7:0]         wdata_ff;
    logic [7:0]         rd_data;
    logic               otp_locked;
    logic               dual_in, dual_out, is_otp;
    logic [`ADDR_BITS-1:0] job_addr_ff;
    logic [`ADDR_BITS-1:0] store_addr;

    pin_sync u_sync (
        .core_clk        (core_clk),
        .reset           (reset),
        .sclk            (sclk),
        .cs_n            (cs_n),
        .hold_n          (hold_n),
        .io_line_zero_in (io_line_zero_in),
        .io_line_one_in  (io_line_one_in),
        .ev              (ev)
    );

    flash_store u_store (
        .core_clk     (core_clk),
        .reset        (reset),
        .addr         (store_addr),
        .otp_sel      (is_otp),
        .wr_en        (wr_pulse_ff),
        .wr_data      (wdata_ff),
        .erase_en     (erase_ff),
        .erase_kind   (job_ff),
        .otp_lock_set (lock_ff),
        .prot_nv      (prot_nv),
        .prot_vol     (prot_vol_ff),
        .rd_data      (rd_data),
        .otp_locked   (otp_locked)
    );

    assign dual_in  = cmd_ff == `OP_DUAL_PROG;
    assign dual_out = cmd_ff == `OP_DUAL_READ;
    assign is_otp   = cmd_ff == `OP_OTP_READ || cmd_ff == `OP_OTP_PROG;
    // Decode state is gone by then, so erase uses the job's own address
    assign store_addr = erase_ff ? job_addr_ff : addr_ff;

    assign io_line_zero_out = z_out_ff;
    assign io_line_zero_oe  = z_oe_ff;
    assign io_line_one_out  = o_out_ff;
    assign io_line_one_oe   = o_oe_ff;
    assign busy             = busy_ff;
    assign standby          = standby_ff;

    // ------------------------------------------------------------
    // Power-up arming
    // ------------------------------------------------------------
    // first select edge arms
    always_ff @(posedge core_clk) begin
        if (reset)
            armed_ff <= 1'b0;
        else if (ev.sel_fall)
            armed_ff <= 1'b1;
    end

    // ------------------------------------------------------------
    // Input shifting and decode
    // ------------------------------------------------------------
    // Busy device ignores new commands; no status read is modelled.
    always_ff @(posedge core_clk) begin
        if (reset || !ev.sel) begin
            ph_ff   <= flash_pkg::PH_CMD;
            cmd_ff  <= 8'h00;
            sh_ff   <= 8'h00;
            cnt_ff  <= 6'h00;
            addr_ff <= '0;
            nbytes_ff <= 9'h000;
        end else if (ev.rise && armed_ff && !busy_ff) begin
            // sample line zero on rising edge
            if (ph_ff == flash_pkg::PH_DATA && (dual_in || dual_out)) begin
                sh_ff  <= {sh_ff[5:0], ev.din[1], ev.din[0]};
                cnt_ff <= cnt_ff + 6'h02;
            end else begin
                sh_ff  <= {sh_ff[6:0], ev.din[0]};
                cnt_ff <= cnt_ff + 6'h01;
            end
            case (ph_ff)
                flash_pkg::PH_CMD: if (cnt_ff == 6'h07) begin
                    cmd_ff <= {sh_ff[6:0], ev.din[0]};
                    cnt_ff <= 6'h00;
                    ph_ff  <= ({sh_ff[6:0], ev.din[0]} == `OP_WRITE_EN ||
                               {sh_ff[6:0], ev.din[0]} == `OP_BULK_ERASE) ?
                              flash_pkg::PH_IDLE : flash_pkg::PH_ADDR;
                end
                flash_pkg::PH_ADDR: begin
                    addr_ff <= {addr_ff[`ADDR_BITS-2:0], ev.din[0]};
                    if (cnt_ff == 6'h17) begin
                        cnt_ff <= 6'h00;
                        ph_ff  <= (dual_out || cmd_ff == `OP_OTP_READ) ?
                                  flash_pkg::PH_DUMMY : flash_pkg::PH_DATA;
                    end
                end
                flash_pkg::PH_DUMMY: if (cnt_ff == 6'h07) begin
                    cnt_ff <= 6'h00;
                    ph_ff  <= flash_pkg::PH_DATA;
                end
                flash_pkg::PH_DATA: if (cnt_ff + bit_step(dual_in || dual_out) == 6'h08) begin
                    cnt_ff <= 6'h00;
                    if (nbytes_ff != `PAGE_BYTES)
                        nbytes_ff <= nbytes_ff + 9'h001;
                    if (nbytes_ff != 9'h000 || !(cmd_ff == `OP_PAGE_PROG ||
                            dual_in || cmd_ff == `OP_OTP_PROG))
                        addr_ff <= {addr_ff[`ADDR_BITS-1:8], addr_ff[7:0] + 8'h01};
                end
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Program data capture
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (reset) begin
            wr_pulse_ff <= 1'b0;
            wdata_ff    <= 8'hff;
        end else begin
            wr_pulse_ff <= 1'b0;
            if (ev.rise && ph_ff == flash_pkg::PH_DATA && wel_ff && !busy_ff &&
                    cnt_ff + bit_step(dual_in) == 6'h08 &&
                    (cmd_ff == `OP_PAGE_PROG || dual_in ||
                     (cmd_ff == `OP_OTP_PROG && !otp_locked))) begin
                wr_pulse_ff <= 1'b1;
                wdata_ff    <= dual_in ? {sh_ff[5:0], ev.din} : {sh_ff[6:0], ev.din[0]};
            end
        end
    end

    // ------------------------------------------------------------
    // Output shifting
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (reset || !ev.sel) begin
            z_out_ff <= 1'b0;
            z_oe_ff  <= 1'b0;
            o_out_ff <= 1'b0;
            o_oe_ff  <= 1'b0;
        end else if (ev.held) begin
            z_oe_ff <= 1'b0;
            o_oe_ff <= 1'b0;
        end else if (ev.fall && ph_ff == flash_pkg::PH_DATA) begin
            if (dual_out) begin
                // both lines drive on falling edge
                o_out_ff <= rd_data[3'h7 - cnt_ff[2:0]];
                z_out_ff <= rd_data[3'h6 - cnt_ff[2:0]];
                o_oe_ff  <= 1'b1;
                z_oe_ff  <= 1'b1;
            end else if (cmd_ff == `OP_READ || cmd_ff == `OP_OTP_READ) begin
                // line one changes on falling edge
                o_out_ff <= rd_data[3'h7 - cnt_ff[2:0]];
                o_oe_ff  <= 1'b1;
            end
        end
    end

    // Bits moved per clock in the data phase
    function automatic logic [5:0] bit_step(input logic two_lines);
        bit_step = two_lines ? 6'h02 : 6'h01;
    endfunction

    // ------------------------------------------------------------
    // Internal cycle and power modes
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (reset) begin
            wel_ff      <= 1'b0;
            busy_ff     <= 1'b0;
            busy_cnt_ff <= 16'h0000;
            job_ff      <= flash_pkg::JOB_NONE;
            erase_ff    <= 1'b0;
            lock_ff     <= 1'b0;
            prot_vol_ff <= 16'h0000;
            job_addr_ff <= '0;
        end else begin
            erase_ff <= 1'b0;
            lock_ff  <= 1'b0;
            if (busy_ff) begin
                busy_cnt_ff <= busy_cnt_ff - 16'h0001;
                if (busy_cnt_ff == 16'h0001) begin
                    busy_ff <= 1'b0;
                    erase_ff <= job_ff inside {flash_pkg::JOB_SUB, flash_pkg::JOB_SEC,
                                               flash_pkg::JOB_BULK};
                end
            end else if (ev.sel_rise && armed_ff) begin
                if (cmd_ff == `OP_WRITE_EN && ph_ff == flash_pkg::PH_IDLE)
                    wel_ff <= 1'b1;
                else if (wel_ff && cmd_ff != 8'h00) begin
                    wel_ff      <= 1'b0;
                    busy_ff     <= 1'b1;
                    busy_cnt_ff <= `BUSY_CYCLES;
                    job_addr_ff <= addr_ff;
                    case (cmd_ff)
                        `OP_SUB_ERASE:  job_ff <= flash_pkg::JOB_SUB;
                        `OP_SEC_ERASE:  job_ff <= flash_pkg::JOB_SEC;
                        `OP_BULK_ERASE: job_ff <= flash_pkg::JOB_BULK;
                        `OP_SET_LOCK: begin
                            job_ff <= flash_pkg::JOB_NONE;
                            prot_vol_ff[addr_ff[19:16]] <= 1'b1;
                        end
                        `OP_OTP_PROG: begin
                            job_ff <= flash_pkg::JOB_OTP;
                            lock_ff <= addr_ff[5:0] == `OTP_LOCK_IDX && !sh_ff[0];
                        end
                        default:        job_ff <= flash_pkg::JOB_PROG;
                    endcase
                end
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset)
            standby_ff <= 1'b1;
        else
            standby_ff <= !ev.sel && !busy_ff;
    end

    a_otp_lock_stays: assert property (@(posedge core_clk) disable iff (reset)
        otp_locked |=> otp_locked) else $error("otp lock reverted");
    a_desel_tristate: assert property (@(posedge core_clk) disable iff (reset)
        !ev.sel |=> !o_oe_ff && !z_oe_ff) else $error("driving while deselected");
    a_hold_release: assert property (@(posedge core_clk) disable iff (reset)
        ev.held |=> !o_oe_ff && !z_oe_ff) else $error("driving during hold");
    a_standby_busy: assert property (@(posedge core_clk) disable iff (reset)
        busy_ff |=> !standby_ff) else $error("standby during cycle");
    a_select_active: assert property (@(posedge core_clk) disable iff (reset)
        ev.sel |=> !standby_ff) else $error("standby while selected");
    a_arm_first: assert property (@(posedge core_clk) disable iff (reset)
        !armed_ff |-> ph_ff == flash_pkg::PH_CMD && cnt_ff == 6'h00)
        else $error("decode before arm");
    a_clear_desel: assert property (@(posedge core_clk) disable iff (reset)
        ev.sel_rise |=> cnt_ff == 6'h00 && cmd_ff == 8'h00) else $error("state kept");
    a_single_out: assert property (@(posedge core_clk) disable iff (reset)
        z_oe_ff |-> dual_out) else $error("line zero driven outside dual read");
    a_out_on_fall: assert property (@(posedge core_clk) disable iff (reset)
        $rose(o_oe_ff) |-> $past(ev.fall)) else $error("output enabled off fall");
endmodule // serial_flash

// file: verif/spi_master_model.sv
// Serial bus master model: drives clock, select and data, reads the lines.
// Assumes the bench wires the design's line outputs and enables in here.
`timescale 1ns/1ps
module spi_master_model (
    output logic      sclk,
    output logic      cs_n,
    output logic      line_zero,
    output logic      line_one,
    input  wire logic z_out,
    input  wire logic z_oe,
    input  wire logic o_out,
    input  wire logic o_oe
);
    logic md0, md1, men0, men1, flip;
    // ----------------------------------------
    // Line levels
    // ----------------------------------------
    // Undriven lines wander so a stale value never passes
    assign line_zero = z_oe ? z_out : (men0 ? md0 : flip);
    assign line_one  = o_oe ? o_out : (men1 ? md1 : flip);
    initial begin
        flip = 1'b0;
        forever #100 flip = ~flip;
    end
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        md0  = 1'b0;
        md1  = 1'b0;
        men0 = 1'b0;
        men1 = 1'b0;
    end
    // ----------------------------------------
    // Frame tasks
    // ----------------------------------------
    // select by low level
    task automatic start();
        men0 = 1'b1;
        #50 cs_n = 1'b0;
        #100;
    endtask
    task automatic stop();
        #100 cs_n = 1'b1;
        men0 = 1'b0;
        men1 = 1'b0;
        #300;
    endtask
    task automatic send(input logic [7:0] b, input int n);
        for (int i = 0; i < n; i++) begin
            md0 = b[7-i];
            #100 sclk = 1'b1;
            #100 sclk = 1'b0;
        end
    endtask
    // line one carries the high bit
    task automatic send_dual(input logic [7:0] b);
        men1 = 1'b1;
        for (int i = 0; i < 4; i++) begin
            md1 = b[7-2*i];
            md0 = b[6-2*i];
            #100 sclk = 1'b1;
            #100 sclk = 1'b0;
        end
    endtask
    // Sampled late in the high phase, after the device's launch delay
    task automatic recv(output logic [7:0] b, input bit dual);
        if (dual) begin
            men0 = 1'b0;
        end
        for (int i = 0; i < (dual ? 4 : 8); i++) begin
            #100 sclk = 1'b1;
            #90;
            b = dual ? {b[5:0], line_one, line_zero} : {b[6:0], line_one};
            #10 sclk = 1'b0;
        end
    endtask
endmodule // spi_master_model

// file: verif/tb_top.sv
// Bench for the serial flash front end: operation table, then hand tests.
// Assumes spi_master_model times the serial pins apart from core_clk.
`timescale 1ns/1ps
`include "flash_params.svh"
module tb_top;
    typedef struct packed {
        logic [7:0]  op;
        logic [23:0] addr;
        logic [7:0]  dat;
    } row_s;
    logic        core_clk, reset, hold_n, sclk, cs_n, line_zero, line_one;
    logic        z_out, z_oe, o_out, o_oe, busy, standby;
    logic [15:0] prot_nv;
    logic [7:0]  got;
    int          errors, compares;
    row_s        rows [16];
    serial_flash i_serial_flash (.core_clk(core_clk), .reset(reset), .sclk(sclk),
        .cs_n(cs_n), .hold_n(hold_n), .io_line_zero_in(line_zero),
        .io_line_zero_out(z_out), .io_line_zero_oe(z_oe), .io_line_one_in(line_one),
        .io_line_one_out(o_out), .io_line_one_oe(o_oe), .prot_nv(prot_nv),
        .busy(busy), .standby(standby));
    spi_master_model i_spi_master_model (.sclk(sclk), .cs_n(cs_n),
        .line_zero(line_zero), .line_one(line_one), .z_out(z_out), .z_oe(z_oe),
        .o_out(o_out), .o_oe(o_oe));
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic conclude();
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] act);
        compares++;
        if (act !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, act);
        end
    endtask
    task automatic wait_busy(input logic lvl, input int lim);
        int k;
        k = 0;
        while (busy !== lvl && k < lim) begin
            tick(1);
            k++;
        end
        if (k >= lim) begin
            check("busy wait", {7'h0, lvl}, {7'h0, busy});
            conclude();
        end
    endtask
    // One selection; write kinds get a write enable first
    task automatic do_op(input row_s r, input bit garb, input bit live);
        logic wr;
        wr = !(r.op inside {`OP_READ, `OP_DUAL_READ, `OP_OTP_READ});
        if (wr) begin
            i_spi_master_model.start();
            i_spi_master_model.send(`OP_WRITE_EN, 8);
            i_spi_master_model.stop();
        end
        i_spi_master_model.start();
        tick(3);
        check("standby sel", 8'h00, {7'h0, standby});
        if (garb) begin
            hold_n = 1'b0;
            i_spi_master_model.send(8'h00, 8);
            tick(1);
            hold_n = 1'b1;
        end
        i_spi_master_model.send(r.op, 8);
        if (r.op != `OP_BULK_ERASE) begin
            for (int i = 2; i >= 0; i--) begin
                i_spi_master_model.send(r.addr[8*i +: 8], 8);
            end
        end
        if (r.op inside {`OP_DUAL_READ, `OP_OTP_READ}) begin
            i_spi_master_model.send(8'h00, 8);
        end
        case (r.op)
            `OP_READ, `OP_OTP_READ: i_spi_master_model.recv(got, 1'b0);
            `OP_DUAL_READ: begin
                i_spi_master_model.recv(got, 1'b1);
                check("dual oe", 8'h01, {7'h0, z_oe & o_oe});
            end
            `OP_DUAL_PROG: begin
                i_spi_master_model.send_dual(r.dat);
                check("line one oe", 8'h00, {7'h0, o_oe});
            end
            `OP_PAGE_PROG, `OP_OTP_PROG: i_spi_master_model.send(r.dat, 8);
            default: ;
        endcase
        if (garb) begin
            hold_n = 1'b0;
            tick(4);
            check("hold oe", 8'h00, {6'h0, z_oe, o_oe});
            hold_n = 1'b1;
        end
        i_spi_master_model.stop();
        check("oe deselected", 8'h00, {6'h0, z_oe, o_oe});
        if (wr && live) begin
            check("busy standby", 8'h02, {6'h0, busy, standby});
        end
        if (wr) begin
            wait_busy(1'b0, 200);
            tick(3);
            check("standby idle", 8'h01, {7'h0, standby});
        end else begin
            check("read data", r.dat, got);
        end
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        reset = 1'b1;
        hold_n = 1'b1;
        prot_nv = 16'h0000;
        errors = 0;
        compares = 0;
        rows = '{'{`OP_BULK_ERASE, 24'h000000, 8'hff}, '{`OP_READ, 24'h000000, 8'hff},
                 '{`OP_PAGE_PROG, 24'h000000, 8'ha5}, '{`OP_PAGE_PROG, 24'h001000, 8'h3c},
                 '{`OP_PAGE_PROG, 24'h010000, 8'h5a}, '{`OP_READ, 24'h000000, 8'ha5},
                 '{`OP_SUB_ERASE, 24'h001010, 8'hff}, '{`OP_READ, 24'h000000, 8'ha5},
                 '{`OP_READ, 24'h001000, 8'hff}, '{`OP_SEC_ERASE, 24'h00ffff, 8'hff},
                 '{`OP_READ, 24'h000000, 8'hff}, '{`OP_READ, 24'h010000, 8'h5a},
                 '{`OP_DUAL_PROG, 24'h020000, 8'hc3}, '{`OP_DUAL_READ, 24'h020000, 8'hc3},
                 '{`OP_OTP_PROG, 24'h000005, 8'h96}, '{`OP_OTP_READ, 24'h000005, 8'h96}};
        tick(1);
        check("reset outs", 8'h01, {5'h0, z_oe | o_oe, busy, standby});
        tick(3);
        reset = 1'b0;
        tick(3);
        // rows erase by scope and keep areas apart
        foreach (rows[i]) begin
            do_op(rows[i], 1'b0, 1'b1);
            $display("row %0d done", i);
        end
        do_op('{`OP_READ, 24'h000005, 8'hff}, 1'b0, 1'b1);
        do_op('{`OP_READ, 24'h010000, 8'h5a}, 1'b1, 1'b1);
        $display("hold test done");
        i_spi_master_model.start();
        i_spi_master_model.send(8'hff, 4);
        i_spi_master_model.stop();
        do_op('{`OP_READ, 24'h010000, 8'h5a}, 1'b0, 1'b1);
        $display("abort test done");
        tick(1);
        prot_nv = 16'h0008;
        do_op('{`OP_PAGE_PROG, 24'h030000, 8'h00}, 1'b0, 1'b0);
        do_op('{`OP_READ, 24'h030000, 8'hff}, 1'b0, 1'b1);
        do_op('{`OP_SET_LOCK, 24'h040000, 8'hff}, 1'b0, 1'b1);
        do_op('{`OP_PAGE_PROG, 24'h040000, 8'h00}, 1'b0, 1'b0);
        do_op('{`OP_READ, 24'h040000, 8'hff}, 1'b0, 1'b1);
        $display("protect test done");
        do_op('{`OP_OTP_PROG, 24'h00003f, 8'h00}, 1'b0, 1'b1);
        do_op('{`OP_OTP_PROG, 24'h000005, 8'h00}, 1'b0, 1'b0);
        do_op('{`OP_OTP_READ, 24'h000005, 8'h96}, 1'b0, 1'b1);
        $display("lock test done");
        i_spi_master_model.start();
        tick(1);
        reset = 1'b1;
        tick(4);
        check("reset again", 8'h01, {5'h0, z_oe | o_oe, busy, standby});
        reset = 1'b0;
        tick(3);
        i_spi_master_model.send(`OP_READ, 8);
        i_spi_master_model.send(8'h01, 8);
        i_spi_master_model.send(8'h00, 8);
        i_spi_master_model.send(8'h00, 8);
        i_spi_master_model.recv(got, 1'b0);
        check("unarmed oe", 8'h00, {6'h0, z_oe, o_oe});
        i_spi_master_model.stop();
        $display("arm test done");
        conclude();
    end
endmodule // tb_top
